// file: rtl/stm_pkg.sv
/*
  Constants, command codes and field layouts for the status and telemetry
  command set of the converter's management interface.
  Assumes a command decoder outside hands whole commands to the block.
*/
// Notes on behaviour
// - Vout byte: bits 7..4 OV/UV faults, warnings
// - Vout bit 3: set point outside min/max
// - Vout bits 2,1 turn-on/off time; bit 0 none
// - Iout byte: bit 7 OC fault, bit 5 warning
// - Input byte: bits 7,5,3,1 as listed
// - Temperature byte: bit 7 fault, bit 6 warning
// - CML bit 7: unknown command code received
// - CML bit 6: bad data for a command
// - CML bit 5: packet error check failed
// - CML bit 4 memory, bit 1 other fault
// - Vendor byte: lead-unit and three NVM faults
// - Status, telemetry, revision are read-only
// - Input voltage reading, two bytes, LINEAR11
// - Input current reading, two bytes, LINEAR11
// - Output voltage reading is sixteen-bit unsigned
// - Output current reading, two bytes, LINEAR11
// - Temperature reading, two bytes, LINEAR11
// - Duty cycle reading, two bytes, LINEAR11
// - Output and input power readings, LINEAR11
// - Revision byte: Part I high, Part II low
// - Serial word is 16-bit, writable, readable
// - LINEAR11 packs 5-bit exponent, 11-bit mantissa
package stm_pkg;
  // Command codes
  localparam logic [7:0] CMD_VOUT_FLAGS = 8'h7a;
  localparam logic [7:0] CMD_IOUT_FLAGS = 8'h7b;
  localparam logic [7:0] CMD_INPUT_FLAGS = 8'h7c;
  localparam logic [7:0] CMD_THERM_FLAGS = 8'h7d;
  localparam logic [7:0] CMD_CML_FLAGS = 8'h7e;
  localparam logic [7:0] CMD_VENDOR_FLAGS = 8'h80;
  localparam logic [7:0] CMD_VIN = 8'h88;
  localparam logic [7:0] CMD_IIN = 8'h89;
  localparam logic [7:0] CMD_VOUT = 8'h8b;
  localparam logic [7:0] CMD_IOUT = 8'h8c;
  localparam logic [7:0] CMD_TEMP = 8'h8d;
  localparam logic [7:0] CMD_DUTY = 8'h94;
  localparam logic [7:0] CMD_POUT = 8'h96;
  localparam logic [7:0] CMD_PIN = 8'h97;
  localparam logic [7:0] CMD_REVISION = 8'h98;
  localparam logic [7:0] CMD_SERIAL = 8'h9e;
  // Implemented bits of each status byte
  localparam logic [7:0] MASK_VOUT = 8'hfe;
  localparam logic [7:0] MASK_IOUT = 8'ha0;
  localparam logic [7:0] MASK_INPUT = 8'haa;
  localparam logic [7:0] MASK_THERM = 8'hc0;
  localparam logic [7:0] MASK_CML = 8'hf2;
  localparam logic [7:0] MASK_VENDOR = 8'h0f;
  // CML bits driven by the block itself, and the ones fed from outside
  localparam int CML_BAD_CMD = 7;
  localparam int CML_BAD_DATA = 6;
  localparam int CML_PEC_FAIL = 5;
  localparam logic [7:0] MASK_CML_EXT = 8'h12;
  // Field sizes
  localparam int MANT_W = 11;
  localparam int EXP_W = 5;
  localparam int WORD_W = 16;
  localparam logic [1:0] BYTES_ONE = 2'h1;
  localparam logic [1:0] BYTES_TWO = 2'h2;
  localparam logic [15:0] SERIAL_RESET = 16'h0000;
  // Revision codes, 4'h3 means revision 1.3
  localparam logic [3:0] REV_PART1 = 4'h3;
  localparam logic [3:0] REV_PART2 = 4'h3;

  // Exponent in the high five bits, mantissa in the low eleven
  function automatic logic [15:0] packLinear11(input logic [10:0] mant, input logic [4:0] expo);
    packLinear11 = {expo, mant};
  endfunction

  // True for every code that this block implements
  function automatic logic isOwnCode(input logic [7:0] code);
    case (code)
      CMD_VOUT_FLAGS, CMD_IOUT_FLAGS, CMD_INPUT_FLAGS, CMD_THERM_FLAGS,
      CMD_CML_FLAGS, CMD_VENDOR_FLAGS, CMD_VIN, CMD_IIN, CMD_VOUT,
      CMD_IOUT, CMD_TEMP, CMD_DUTY, CMD_POUT, CMD_PIN, CMD_REVISION,
      CMD_SERIAL: isOwnCode = 1'b1;
      default: isOwnCode = 1'b0;
    endcase
  endfunction
endpackage

// file: rtl/stm_flag_byte.sv
/*
  One sticky status byte: events set bits, a clear pulse drops them.
  Assumes events and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
module stm_flag_byte #(
  parameter logic [7:0] IMPL = 8'hff
) (
  input wire logic clk, // System clock
  input wire logic reset, // Asynchronous reset, active high
  input wire logic [7:0] setEvt, // Event bits, level or pulse
  input wire logic clearAll, // Clear all latched bits
  output logic [7:0] flags // Latched status byte
);
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;

  // Set wins over a clear in the same cycle so no event is lost
  assign flags_nxt = (flags_r & ~{8{clearAll}}) | (setEvt & IMPL);
  assign flags = flags_r;

  // Latched byte, only implemented bits can ever rise
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flags_r <= 8'h00;
    end else begin
      flags_r <= flags_nxt;
    end
  end
endmodule // stm_flag_byte

// file: rtl/stm_status_telemetry_regs.sv
/*
  Status bytes, telemetry words, revision byte and user serial word of the
  converter's management command set.
  Assumes an outside bus engine decodes address and command code, checks
  the packet error byte and hands over one whole command per cvalid pulse;
  telemetry and fault events come from converter logic on the same clock.
*/
`timescale 1ns/1ps
module stm_status_telemetry_regs (
  input wire logic clk, // System clock, 10 MHz
  input wire logic reset, // Asynchronous reset, active high
  input wire logic cmdValid, // One-cycle command strobe
  input wire logic [7:0] cmdCode, // Command code
  input wire logic cmdWrite, // High for a write command
  input wire logic [1:0] cmdBytes, // Data bytes in a write
  input wire logic [stm_pkg::WORD_W-1:0] cmdData, // Write data, low byte first on bus
  input wire logic cmdPecFail, // Packet error check failed
  input wire logic otherClaimed, // Another block owns cmdCode
  input wire logic clearFaults, // Clear all status bytes
  input wire logic [7:0] evVout, // Output voltage events
  input wire logic [7:0] evIout, // Output current events
  input wire logic [7:0] evInput, // Input events
  input wire logic [7:0] evTherm, // Temperature events
  input wire logic [7:0] evCml, // Memory and other comm faults
  input wire logic [7:0] evVendor, // Lead-unit and NVM faults
  input wire logic [stm_pkg::MANT_W-1:0] vinMant, // Input voltage mantissa
  input wire logic [stm_pkg::EXP_W-1:0] vinExp, // Input voltage exponent
  input wire logic [stm_pkg::MANT_W-1:0] iinMant, // Input current mantissa
  input wire logic [stm_pkg::EXP_W-1:0] iinExp, // Input current exponent
  input wire logic [stm_pkg::WORD_W-1:0] voutRaw, // Output voltage, unsigned
  input wire logic [stm_pkg::MANT_W-1:0] ioutMant, // Output current mantissa
  input wire logic [stm_pkg::EXP_W-1:0] ioutExp, // Output current exponent
  input wire logic [stm_pkg::MANT_W-1:0] tempMant, // Temperature mantissa
  input wire logic [stm_pkg::EXP_W-1:0] tempExp, // Temperature exponent
  input wire logic [stm_pkg::MANT_W-1:0] dutyMant, // Duty cycle mantissa
  input wire logic [stm_pkg::EXP_W-1:0] dutyExp, // Duty cycle exponent
  input wire logic [stm_pkg::MANT_W-1:0] poutMant, // Output power mantissa
  input wire logic [stm_pkg::EXP_W-1:0] poutExp, // Output power exponent
  input wire logic [stm_pkg::MANT_W-1:0] pinMant, // Input power mantissa
  input wire logic [stm_pkg::EXP_W-1:0] pinExp, // Input power exponent
  output logic rspValid, // One-cycle answer strobe
  output logic rspError, // Command refused
  output logic [1:0] rspBytes, // Bytes in rspData
  output logic [stm_pkg::WORD_W-1:0] rspData, // Read data
  output logic [7:0] summaryBits // Or of each status byte, vout first
);
  import stm_pkg::*;

  logic [7:0] fVout;
  logic [7:0] fIout;
  logic [7:0] fInput;
  logic [7:0] fTherm;
  logic [7:0] fCml;
  logic [7:0] fVendor;
  logic [7:0] cmlEvt;
  logic [15:0] serial_r;
  logic [15:0] serial_nxt;
  logic rspValid_r;
  logic rspError_r;
  logic [1:0] rspBytes_r;
  logic [15:0] rspData_r;
  logic [15:0] readWord;
  logic [1:0] readBytes;
  logic ownCode;
  logic accepted;
  logic badCmd;
  logic badData;
  logic serialWr;
  logic answered;
  logic [15:0] vinWord;
  logic [15:0] iinWord;
  logic [15:0] ioutWord;
  logic [15:0] tempWord;
  logic [15:0] dutyWord;
  logic [15:0] poutWord;
  logic [15:0] pinWord;

  // Command classification; a failed check voids the whole command
  assign ownCode = isOwnCode(cmdCode);
  assign accepted = cmdValid && !cmdPecFail && ownCode;
  assign badCmd = cmdValid && !cmdPecFail && !ownCode && !otherClaimed;
  assign serialWr = accepted && cmdWrite && (cmdCode == CMD_SERIAL)
                    && (cmdBytes == BYTES_TWO);
  // A foreign code claimed by another block gets no answer at all, not even an error
  assign answered = cmdValid && (ownCode || !otherClaimed);
  // Writes to read-only codes, or a serial write of the wrong size
  assign badData = accepted && cmdWrite && !serialWr;

  // Own CML events, plus memory and other faults from outside
  assign cmlEvt = (evCml & MASK_CML_EXT)
                  | ({7'h00, badCmd} << CML_BAD_CMD)
                  | ({7'h00, badData} << CML_BAD_DATA)
                  | ({7'h00, cmdValid && cmdPecFail} << CML_PEC_FAIL);

  // Status bytes; masks keep absent bits at zero
  stm_flag_byte #(.IMPL(MASK_VOUT)) uVout (
    .clk(clk),
    .reset(reset),
    .setEvt(evVout),
    .clearAll(clearFaults),
    .flags(fVout)
  );
  stm_flag_byte #(.IMPL(MASK_IOUT)) uIout (
    .clk(clk),
    .reset(reset),
    .setEvt(evIout),
    .clearAll(clearFaults),
    .flags(fIout)
  );
  stm_flag_byte #(.IMPL(MASK_INPUT)) uInput (
    .clk(clk),
    .reset(reset),
    .setEvt(evInput),
    .clearAll(clearFaults),
    .flags(fInput)
  );
  stm_flag_byte #(.IMPL(MASK_THERM)) uTherm (
    .clk(clk),
    .reset(reset),
    .setEvt(evTherm),
    .clearAll(clearFaults),
    .flags(fTherm)
  );
  stm_flag_byte #(.IMPL(MASK_CML)) uCml (
    .clk(clk),
    .reset(reset),
    .setEvt(cmlEvt),
    .clearAll(clearFaults),
    .flags(fCml)
  );
  stm_flag_byte #(.IMPL(MASK_VENDOR)) uVendor (
    .clk(clk),
    .reset(reset),
    .setEvt(evVendor),
    .clearAll(clearFaults),
    .flags(fVendor)
  );

  // Telemetry words packed as exponent over mantissa
  assign vinWord = packLinear11(vinMant, vinExp);
  assign iinWord = packLinear11(iinMant, iinExp);
  assign ioutWord = packLinear11(ioutMant, ioutExp);
  assign tempWord = packLinear11(tempMant, tempExp);
  assign dutyWord = packLinear11(dutyMant, dutyExp);
  assign poutWord = packLinear11(poutMant, poutExp);
  assign pinWord = packLinear11(pinMant, pinExp);

  // Read selection; the outside engine sends rspBytes bytes, low first
  always_comb begin
    readWord = 16'h0000;
    readBytes = BYTES_TWO;
    case (cmdCode)
      CMD_VOUT_FLAGS: begin
        readWord = {8'h00, fVout};
        readBytes = BYTES_ONE;
      end
      CMD_IOUT_FLAGS: begin
        readWord = {8'h00, fIout};
        readBytes = BYTES_ONE;
      end
      CMD_INPUT_FLAGS: begin
        readWord = {8'h00, fInput};
        readBytes = BYTES_ONE;
      end
      CMD_THERM_FLAGS: begin
        readWord = {8'h00, fTherm};
        readBytes = BYTES_ONE;
      end
      CMD_CML_FLAGS: begin
        readWord = {8'h00, fCml};
        readBytes = BYTES_ONE;
      end
      CMD_VENDOR_FLAGS: begin
        readWord = {8'h00, fVendor};
        readBytes = BYTES_ONE;
      end
      CMD_REVISION: begin
        readWord = {8'h00, REV_PART1, REV_PART2};
        readBytes = BYTES_ONE;
      end
      CMD_VIN: readWord = vinWord;
      CMD_IIN: readWord = iinWord;
      CMD_VOUT: readWord = voutRaw;
      CMD_IOUT: readWord = ioutWord;
      CMD_TEMP: readWord = tempWord;
      CMD_DUTY: readWord = dutyWord;
      CMD_POUT: readWord = poutWord;
      CMD_PIN: readWord = pinWord;
      CMD_SERIAL: readWord = serial_r;
      default: readWord = 16'h0000;
    endcase
  end

  // Only the serial word is writable; nothing else has a write path
  assign serial_nxt = serialWr ? cmdData : serial_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      serial_r <= SERIAL_RESET;
    end else begin
      serial_r <= serial_nxt;
    end
  end

  // Answer registered one cycle after the command strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rspValid_r <= 1'b0;
      rspError_r <= 1'b0;
      rspBytes_r <= 2'h0;
      rspData_r <= 16'h0000;
    end else begin
      rspValid_r <= answered;
      rspError_r <= answered && !(accepted && !badData);
      rspBytes_r <= (accepted && !cmdWrite) ? readBytes : 2'h0;
      rspData_r <= (accepted && !cmdWrite) ? readWord : 16'h0000;
    end
  end

  assign rspValid = rspValid_r;
  assign rspError = rspError_r;
  assign rspBytes = rspBytes_r;
  assign rspData = rspData_r;
  // Handy for building the summary status outside
  assign summaryBits = {|fVout, |fIout, |fInput, |fTherm, |fCml, |fVendor, 2'h0};

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_answer_next_cycle: assert property (cmdValid && ownCode |=> rspValid)
    else $error("answer missing one cycle after own command");
  a_pec_sets_flag: assert property (cmdValid && cmdPecFail |=> fCml[5])
    else $error("packet check failure not flagged");
  a_bad_cmd_flag: assert property (
    cmdValid && !cmdPecFail && !ownCode && !otherClaimed |=> fCml[7] && rspError)
    else $error("unknown command not flagged");
  a_ro_write_flag: assert property (
    cmdValid && !cmdPecFail && cmdWrite && ownCode && cmdCode != CMD_SERIAL |=> fCml[6])
    else $error("write to read-only command not flagged");
  a_serial_write: assert property (
    cmdValid && !cmdPecFail && cmdWrite && cmdCode == CMD_SERIAL && cmdBytes == BYTES_TWO
    |=> serial_r == $past(cmdData))
    else $error("serial word not written");
  a_serial_hold: assert property (
    !(cmdValid && !cmdPecFail && cmdWrite && cmdCode == CMD_SERIAL && cmdBytes == BYTES_TWO)
    |=> $stable(serial_r))
    else $error("serial word changed without its write");
  a_vin_packing: assert property (
    cmdValid && !cmdPecFail && !cmdWrite && cmdCode == CMD_VIN
    |=> rspData == {$past(vinExp), $past(vinMant)} && rspBytes == BYTES_TWO)
    else $error("input voltage word mispacked");
  a_rev_byte: assert property (
    cmdValid && !cmdPecFail && !cmdWrite && cmdCode == CMD_REVISION
    |=> rspData == 16'h0033 && rspBytes == BYTES_ONE)
    else $error("revision byte wrong");
  a_unused_zero: assert property (
    fTherm[5:0] == 6'h00 && fIout[6] == 1'b0 && fCml[2] == 1'b0 && fVendor[7:4] == 4'h0
    && fVout[0] == 1'b0)
    else $error("unimplemented status bit set");
  a_flag_sticky: assert property (
    fVout[7] && !clearFaults |=> fVout[7])
    else $error("status bit dropped without clear");
  a_set_wins: assert property (
    evTherm[7] && clearFaults |=> fTherm[7])
    else $error("event lost to clear");

  // Answer framing: silent for claimed foreign codes, empty unless a good read; then flag set and clear timing
  a_claimed_silent: assert property (
    cmdValid && !ownCode && otherClaimed |=> !rspValid && !rspError)
    else $error("claimed foreign code answered");
  a_answer_once: assert property (!cmdValid |=> !rspValid)
    else $error("answer without a command");
  a_rsp_idle: assert property (
    !rspValid |-> !rspError && rspBytes == 2'h0 && rspData == 16'h0000)
    else $error("answer fields set while idle");
  a_write_empty: assert property (
    cmdValid && cmdWrite |=> rspBytes == 2'h0 && rspData == 16'h0000)
    else $error("write answered with data");
  a_set_latency: assert property (evVout[7] |=> fVout[7])
    else $error("event not latched next cycle");
  a_clear_drops: assert property (
    clearFaults && evVout == 8'h00 |=> fVout == 8'h00)
    else $error("clear left a status bit set");

  // Read path: each code returns its own register as it stood in the command cycle
  a_vout_read: assert property (
    cmdValid && !cmdPecFail && !cmdWrite && cmdCode == CMD_VOUT_FLAGS
    |=> rspData == {8'h00, $past(fVout)} && rspBytes == BYTES_ONE)
    else $error("output voltage status read wrong");
  a_iout_read: assert property (
    cmdValid && !cmdPecFail && !cmdWrite && cmdCode == CMD_IOUT_FLAGS
    |=> rspData == {8'h00, $past(fIout)} && rspBytes == BYTES_ONE)
    else $error("output current status read wrong");
  a_input_read: assert property (
    cmdValid && !cmdPecFail && !cmdWrite && cmdCode == CMD_INPUT_FLAGS
    |=> rspData == {8'h00, $past(fInput)} && rspBytes == BYTES_ONE)
    else $error("input status read wrong");
  a_therm_read: assert property (
    cmdValid && !cmdPecFail && !cmdWrite && cmdCode == CMD_THERM_FLAGS
    |=> rspData == {8'h00, $past(fTherm)} && rspBytes == BYTES_ONE)
    else $error("temperature status read wrong");
  a_cml_read: assert property (
    cmdValid && !cmdPecFail && !cmdWrite && cmdCode == CMD_CML_FLAGS
    |=> rspData == {8'h00, $past(fCml)} && rspBytes == BYTES_ONE)
    else $error("comm status read wrong");
  a_vendor_read: assert property (
    cmdValid && !cmdPecFail && !cmdWrite && cmdCode == CMD_VENDOR_FLAGS
    |=> rspData == {8'h00, $past(fVendor)} && rspBytes == BYTES_ONE)
    else $error("vendor status read wrong");
  a_iin_packing: assert property (
    cmdValid && !cmdPecFail && !cmdWrite && cmdCode == CMD_IIN
    |=> rspData == {$past(iinExp), $past(iinMant)} && rspBytes == BYTES_TWO)
    else $error("input current word mispacked");
  a_vout_raw: assert property (
    cmdValid && !cmdPecFail && !cmdWrite && cmdCode == CMD_VOUT
    |=> rspData == $past(voutRaw) && rspBytes == BYTES_TWO)
    else $error("output voltage word wrong");
  a_iout_packing: assert property (
    cmdValid && !cmdPecFail && !cmdWrite && cmdCode == CMD_IOUT
    |=> rspData == {$past(ioutExp), $past(ioutMant)} && rspBytes == BYTES_TWO)
    else $error("output current word mispacked");
  a_temp_packing: assert property (
    cmdValid && !cmdPecFail && !cmdWrite && cmdCode == CMD_TEMP
    |=> rspData == {$past(tempExp), $past(tempMant)} && rspBytes == BYTES_TWO)
    else $error("temperature word mispacked");
  a_duty_packing: assert property (
    cmdValid && !cmdPecFail && !cmdWrite && cmdCode == CMD_DUTY
    |=> rspData == {$past(dutyExp), $past(dutyMant)} && rspBytes == BYTES_TWO)
    else $error("duty cycle word mispacked");
  a_pout_packing: assert property (
    cmdValid && !cmdPecFail && !cmdWrite && cmdCode == CMD_POUT
    |=> rspData == {$past(poutExp), $past(poutMant)} && rspBytes == BYTES_TWO)
    else $error("output power word mispacked");
  a_pin_packing: assert property (
    cmdValid && !cmdPecFail && !cmdWrite && cmdCode == CMD_PIN
    |=> rspData == {$past(pinExp), $past(pinMant)} && rspBytes == BYTES_TWO)
    else $error("input power word mispacked");
  a_serial_read: assert property (
    cmdValid && !cmdPecFail && !cmdWrite && cmdCode == CMD_SERIAL
    |=> rspData == $past(serial_r) && rspBytes == BYTES_TWO)
    else $error("serial word read wrong");

  c_input_voltage_reading: cover property (cmdValid && !cmdWrite && cmdCode == CMD_VIN ##1 rspValid);
  c_write_serial: cover property (serialWr ##1 rspValid && !rspError);
  c_pec_fail: cover property (cmdValid && cmdPecFail ##1 rspError);
  c_clear_flags: cover property (fVout[7] ##1 clearFaults ##1 !fVout[7]);
endmodule // stm_status_telemetry_regs

// file: sim/stm_host_model.sv
/*
  Host-side model of the management bus engine: it issues one command at a
  time on the block's command port and takes the one-cycle answer.
  Assumes the block answers exactly one clock after it takes a command.
*/
`timescale 1ns/1ps
module stm_host_model (
  input wire logic clk, // System clock
  output logic cmdValid, // Command strobe
  output logic [7:0] cmdCode, // Command code
  output logic cmdWrite, // Write flag
  output logic [1:0] cmdBytes, // Data bytes in a write
  output logic [15:0] cmdData, // Write data
  output logic cmdPecFail, // Packet check failed
  output logic otherClaimed, // Code owned by another block
  input wire logic rspValid, // Answer strobe
  input wire logic rspError, // Answer refused
  input wire logic [1:0] rspBytes, // Answer byte count
  input wire logic [15:0] rspData // Answer data
);
  // Idle values at time zero
  initial begin
    cmdValid = 1'b0;
    cmdCode = 8'h00;
    cmdWrite = 1'b0;
    cmdBytes = 2'h0;
    cmdData = 16'h0000;
    cmdPecFail = 1'b0;
    otherClaimed = 1'b0;
  end

  // One command: idle gap, one-cycle strobe, answer taken in the cycle after.
  // Code and data are scrambled once the strobe drops, so a block that
  // samples late never sees the old value again.
  task automatic xfer(input logic [7:0] code, input logic wr, input logic [1:0] nb, input logic [15:0] data,
                      input logic pec, input logic claimed, input int gap,
                      output logic [3:0] stat, output logic [15:0] rdata);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdCode <= code;
    cmdWrite <= wr;
    cmdBytes <= nb;
    cmdData <= data;
    cmdPecFail <= pec;
    otherClaimed <= claimed;
    @(posedge clk);
    cmdValid <= 1'b0;
    cmdCode <= ~code;
    cmdData <= ~data;
    cmdPecFail <= 1'b0;
    otherClaimed <= 1'b0;
    @(negedge clk);
    stat = {rspValid, rspError, rspBytes};
    rdata = rspData;
  endtask
endmodule // stm_host_model

// file: sim/tb_top.sv
/*
  Self-checking bench for the status and telemetry command set: commands go
  through the host model, events and readings are driven by the bench.
  Assumes the package constants and the one-cycle answer of the block.
*/
`timescale 1ns/1ps
module tb_top;
  import stm_pkg::*;
  localparam int LIMIT = 2000;
  logic clk, reset, clearFaults, cmdValid, cmdWrite, cmdPecFail, otherClaimed, rspValid, rspError;
  logic [7:0] cmdCode, evVout, evIout, evInput, evTherm, evCml, evVendor, summaryBits;
  logic [1:0] cmdBytes, rspBytes;
  logic [15:0] cmdData, rspData, voutRaw;
  logic [10:0] vinMant, iinMant, ioutMant, tempMant, dutyMant, poutMant, pinMant;
  logic [4:0] vinExp, iinExp, ioutExp, tempExp, dutyExp, poutExp, pinExp;
  logic [3:0] st;
  logic [15:0] d;
  int errors = 0;
  int nCompared = 0;
  int cycles = 0;
  // Status codes with the bits that each may hold; CML only takes bits 4 and 1 from events
  logic [7:0] flagCodes [6] = '{CMD_VOUT_FLAGS, CMD_IOUT_FLAGS, CMD_INPUT_FLAGS, CMD_THERM_FLAGS,
                                CMD_CML_FLAGS, CMD_VENDOR_FLAGS};
  logic [7:0] flagMask [6] = '{8'hfe, 8'ha0, 8'haa, 8'hc0, 8'h12, 8'h0f};
  // Readings as {exponent, mantissa}, chosen with signs and extremes in both fields
  logic [7:0] telCodes [7] = '{CMD_VIN, CMD_IIN, CMD_IOUT, CMD_TEMP, CMD_DUTY, CMD_POUT, CMD_PIN};
  logic [15:0] telem [7] = '{16'hf3ff, 16'h0801, 16'h7c00, 16'h8005, 16'hd4aa, 16'h1234, 16'hfffe};

  stm_status_telemetry_regs dut_u (.clk(clk), .reset(reset), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdWrite(cmdWrite), .cmdBytes(cmdBytes), .cmdData(cmdData), .cmdPecFail(cmdPecFail),
    .otherClaimed(otherClaimed), .clearFaults(clearFaults), .evVout(evVout), .evIout(evIout),
    .evInput(evInput), .evTherm(evTherm), .evCml(evCml), .evVendor(evVendor),
    .vinMant(vinMant), .vinExp(vinExp), .iinMant(iinMant), .iinExp(iinExp), .voutRaw(voutRaw),
    .ioutMant(ioutMant), .ioutExp(ioutExp), .tempMant(tempMant), .tempExp(tempExp),
    .dutyMant(dutyMant), .dutyExp(dutyExp), .poutMant(poutMant), .poutExp(poutExp),
    .pinMant(pinMant), .pinExp(pinExp), .rspValid(rspValid), .rspError(rspError),
    .rspBytes(rspBytes), .rspData(rspData), .summaryBits(summaryBits));

  stm_host_model host_u (.clk(clk), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdWrite(cmdWrite),
    .cmdBytes(cmdBytes), .cmdData(cmdData), .cmdPecFail(cmdPecFail), .otherClaimed(otherClaimed),
    .rspValid(rspValid), .rspError(rspError), .rspBytes(rspBytes), .rspData(rspData));

  // Closing report, reached from the main sequence or the timeout
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", nCompared, errors);
    if (errors == 0 && nCompared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Answer status as {valid, error, bytes}
  task automatic checkStatus(input logic [3:0] got, input logic [3:0] exp);
    nCompared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: answer status got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic checkData(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: data got %h expected %h", $time, got, exp);
    end
  endtask

  // Good read of nb bytes
  task automatic rd(input logic [7:0] code, input logic [1:0] nb, input logic [15:0] exp);
    host_u.xfer(code, 1'b0, 2'h0, 16'h0000, 1'b0, 1'b0, 0, st, d);
    checkStatus(st, {2'b10, nb});
    checkData(d, exp);
  endtask

  // Command that must be refused with an empty answer
  task automatic refused(input logic [7:0] code, input logic wr, input logic [1:0] nb, input logic [15:0] data,
                         input logic pec);
    host_u.xfer(code, wr, nb, data, pec, 1'b0, 0, st, d);
    checkStatus(st, 4'hc);
    checkData(d, 16'h0000);
  endtask

  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Hang guard: the sequence needs a little over a hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      $display("ERROR at %0t: cycle count got %h expected below %h", $time, cycles, LIMIT);
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    reset = 1'b1;
    clearFaults = 1'b0;
    {evVout, evIout, evInput, evTherm, evCml, evVendor} = '0;
    {vinExp, vinMant} = telem[0];
    {iinExp, iinMant} = telem[1];
    {ioutExp, ioutMant} = telem[2];
    {tempExp, tempMant} = telem[3];
    {dutyExp, dutyMant} = telem[4];
    {poutExp, poutMant} = telem[5];
    {pinExp, pinMant} = telem[6];
    voutRaw = 16'hbeef;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(flagCodes[i], 2'h1, 16'h0000);
    end
    rd(CMD_SERIAL, 2'h2, 16'h0000);
    rd(CMD_REVISION, 2'h1, 16'h0033);
    $display("Test reset values done");
    for (int i = 0; i < 7; i++) begin
      rd(telCodes[i], 2'h2, telem[i]);
    end
    rd(CMD_VOUT, 2'h2, 16'hbeef);
    $display("Test telemetry done");
    // One-cycle pulse on every event bit; flags must survive it
    @(posedge clk);
    {evVout, evIout, evInput, evTherm, evCml, evVendor} <= {6{8'hff}};
    @(posedge clk);
    {evVout, evIout, evInput, evTherm, evCml, evVendor} <= '0;
    for (int i = 0; i < 6; i++) begin
      rd(flagCodes[i], 2'h1, {8'h00, flagMask[i]});
    end
    checkData({8'h00, summaryBits}, 16'h00fc);
    refused(CMD_VOUT_FLAGS, 1'b1, 2'h1, 16'h0000, 1'b0);
    rd(CMD_VOUT_FLAGS, 2'h1, 16'h00fe);
    // Clear together with a new event: the event wins
    @(posedge clk);
    clearFaults <= 1'b1;
    evTherm <= 8'hc0;
    @(posedge clk);
    clearFaults <= 1'b0;
    evTherm <= 8'h00;
    rd(CMD_THERM_FLAGS, 2'h1, 16'h00c0);
    rd(CMD_VOUT_FLAGS, 2'h1, 16'h0000);
    rd(CMD_CML_FLAGS, 2'h1, 16'h0000);
    $display("Test status flags done");
    refused(8'h55, 1'b0, 2'h0, 16'h0000, 1'b0);
    rd(CMD_CML_FLAGS, 2'h1, 16'h0080);
    // Code owned elsewhere, sent after a slow gap: no answer at all
    host_u.xfer(8'h56, 1'b0, 2'h0, 16'h0000, 1'b0, 1'b1, 3, st, d);
    checkStatus(st, 4'h0);
    refused(CMD_SERIAL, 1'b1, 2'h2, 16'h1111, 1'b1);
    rd(CMD_CML_FLAGS, 2'h1, 16'h00a0);
    refused(CMD_VIN, 1'b1, 2'h2, 16'h5555, 1'b0);
    refused(CMD_SERIAL, 1'b1, 2'h1, 16'h00aa, 1'b0);
    rd(CMD_CML_FLAGS, 2'h1, 16'h00e0);
    rd(CMD_VIN, 2'h2, telem[0]);
    rd(CMD_SERIAL, 2'h2, 16'h0000);
    host_u.xfer(CMD_SERIAL, 1'b1, 2'h2, 16'ha5c3, 1'b0, 1'b0, 0, st, d);
    checkStatus(st, 4'h8);
    rd(CMD_SERIAL, 2'h2, 16'ha5c3);
    rd(CMD_CML_FLAGS, 2'h1, 16'h00e0);
    $display("Test command faults and serial done");
    // Reset in mid-run drops flags and the serial word
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(CMD_SERIAL, 2'h2, 16'h0000);
    rd(CMD_CML_FLAGS, 2'h1, 16'h0000);
    $display("Test second reset done");
    give_verdict();
  end
endmodule // tb_top
